// ### dbg_pkg.sv
// Constants for the external debug feature, sample and reserve control registers.
// Assumes a 12-bit byte address on the debug register port and 32-bit data.
package dbg_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_RESERVE_CONTROL = 12'h090;
  localparam logic [11:0] OFF_PC_SAMPLE       = 12'h0a0;
  localparam logic [11:0] OFF_PFR_LOW         = 12'hd20;
  localparam logic [11:0] OFF_PFR_HIGH        = 12'hd24;
  localparam logic [11:0] OFF_DFR_LOW         = 12'hd28;
  localparam logic [11:0] OFF_DFR_HIGH        = 12'hd2c;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int PERF_MON_LSB    = 8;
  localparam int TRACE_IF_LSB    = 4;
  localparam int IRQ_CTRL_IF_LSB = 24;
  localparam int VECTOR_LSB      = 20;
  localparam int FLOAT_LSB       = 16;
  localparam int TOP_LEVEL_LSB   = 12;
  localparam int HYP_LEVEL_LSB   = 8;
  localparam int KERNEL_LSB      = 4;
  localparam int USER_LSB        = 0;
  localparam int CMD_CLEAR_PIPE_BIT   = 3;
  localparam int CMD_CLEAR_STICKY_BIT = 2;
  localparam int REGIME_BIT      = 31;
  localparam int VMID_W          = 8;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] PERF_MON_NONE    = 4'h0;
  localparam logic [3:0] PERF_MON_V3      = 4'h1;
  localparam logic [3:0] PERF_MON_VENDOR  = 4'hf;
  localparam logic [3:0] TRACE_IF_NONE    = 4'h0;
  localparam logic [3:0] TRACE_IF_SYSREG  = 4'h1;
  localparam logic [3:0] IRQ_CTRL_IF_NONE = 4'h0;
  localparam logic [3:0] IRQ_CTRL_IF_V30  = 4'h1;
  localparam logic [3:0] UNIT_PRESENT     = 4'h0;
  localparam logic [3:0] UNIT_ABSENT      = 4'hf;
  localparam logic [3:0] STATE_NARROW_ONLY = 4'h0;
  localparam logic [3:0] STATE_WIDE_ONLY   = 4'h1;
  localparam logic [3:0] STATE_BOTH        = 4'h2;

  // ----------------------------------------------------------------
  // Build configuration
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_PERF_MON     = PERF_MON_V3;
  localparam logic [3:0] CFG_TRACE_IF     = TRACE_IF_NONE;
  localparam logic [3:0] CFG_IRQ_CTRL_IF  = IRQ_CTRL_IF_V30;
  localparam logic [3:0] CFG_VECTOR       = UNIT_PRESENT;
  localparam logic [3:0] CFG_FLOAT        = UNIT_PRESENT;
  localparam logic       CFG_PC_SAMPLE_ON = 1'b1;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [31:0] SAMPLE_ALL_ONES = 32'hffffffff;
  localparam logic [31:0] SAMPLE_RESET    = 32'h00000000;
  localparam logic [31:0] READ_ZERO       = 32'h00000000;

  typedef enum logic [1:0] {ACC_OK, ACC_IGNORE, ACC_ERROR} access_t;

endpackage

// ### pc_sampler.sv
// Program counter sampler: tracks retired instructions and the identifier samples.
// Assumes retire information comes from core logic on the same clock.
`timescale 1ns/1ps
module pc_sampler (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        retire_in,
  input  wire logic [31:0] retire_pc_in,
  input  wire logic [31:0] retire_ctx_in,
  input  wire logic [7:0]  retire_vmid_in,
  input  wire logic        retire_regime_in,
  input  wire logic        halted_in,
  input  wire logic        prohibited_in,
  input  wire logic        core_in_reset_in,
  input  wire logic        sample_read_in,
  input  wire logic        side_effect_en_in,
  output logic      [31:0] sample_value_out,
  output logic      [31:0] ctx_sample_out,
  output logic      [31:0] vm_sample_out
);
  import dbg_pkg::*;

  logic [31:0] last_pc_r;
  logic [31:0] last_ctx_r;
  logic [31:0] last_vm_r;
  logic        fresh_r;
  logic        fresh_nxt;
  logic        blank_w;
  logic        load_w;

  // ----------------------------------------------------------------
  // Sample validity
  // ----------------------------------------------------------------
  // A sample is only meaningful after a retirement in running, permitted state
  assign blank_w = halted_in | prohibited_in | core_in_reset_in | ~fresh_r;  // [R3] [R5]
  // New retirement wins over the read that consumes the previous one
  assign fresh_nxt = retire_in ? 1'b1
                   : (sample_read_in | halted_in | prohibited_in | core_in_reset_in) ? 1'b0
                   : fresh_r;  // [R4] [R5]
  assign sample_value_out = blank_w ? SAMPLE_ALL_ONES : last_pc_r;  // [R3] [R7]
  assign load_w = sample_read_in & side_effect_en_in;  // [R9]

  // ----------------------------------------------------------------
  // Storage, cold reset only
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin  // [R10]
    if (!rstn_in) begin
      last_pc_r  <= SAMPLE_RESET;
      last_ctx_r <= SAMPLE_RESET;
      last_vm_r  <= SAMPLE_RESET;
      fresh_r    <= 1'b0;
    end else begin
      fresh_r <= fresh_nxt;
      if (retire_in) begin
        last_pc_r  <= retire_pc_in;
        last_ctx_r <= retire_ctx_in;
        last_vm_r  <= {retire_regime_in, {(31 - VMID_W){1'b0}}, retire_vmid_in};  // [R8]
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctx_sample_out <= SAMPLE_RESET;
      vm_sample_out  <= SAMPLE_RESET;
    end else if (load_w) begin
      ctx_sample_out <= blank_w ? SAMPLE_ALL_ONES : last_ctx_r;  // [R6] [R7]
      vm_sample_out  <= blank_w ? SAMPLE_ALL_ONES : last_vm_r;  // [R6] [R7] [R8]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_halt_all_ones: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R3]
    (halted_in || prohibited_in) |-> sample_value_out == SAMPLE_ALL_ONES)
    else $error("sample not all ones while halted or prohibited");
  a_side_load_ids: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R7]
    (load_w && !blank_w) |=> (ctx_sample_out == $past(last_ctx_r)) && (vm_sample_out == $past(last_vm_r)))
    else $error("identifier samples not loaded with the sample");
  a_lock_keeps_ids: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R9]
    (sample_read_in && !side_effect_en_in) |=> $stable(ctx_sample_out) && $stable(vm_sample_out))
    else $error("identifier samples changed under software lock");
  a_regime_follows: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R8]
    retire_in |=> last_vm_r[REGIME_BIT] == $past(retire_regime_in))
    else $error("regime bit not captured");

endmodule

// ### ext_debug_regs.sv
// External debug feature, program counter sample and reserve control registers.
// Assumes the debug register port, locks and core status share clock_in.
`timescale 1ns/1ps
// Functional notes
// R1 - Performance monitor version in debug feature [11:8]
// R2 - Trace interface version in debug feature [7:4]
// R3 - Sample reads all ones when halted/prohibited
// R4 - First sample read may return all ones
// R5 - Sample undefined without fresh retirement
// R6 - Blank sample read blanks identifier samples
// R7 - Valid sample read loads identifier samples
// R8 - Regime bit records captured translation regime
// R9 - Software lock suppresses memory-mapped side effect
// R10 - Sample resets on cold reset only
// R11 - Sample register exists only when built
// R12 - Interrupt controller interface in feature [27:24]
// R13 - Vector unit presence in feature [23:20]
// R14 - Float unit presence in feature [19:16]
// R15 - Top level field fixed at zero
// R16 - Hypervisor level field fixed at zero
// R17 - Kernel level field fixed at zero
// R18 - User level field fixed at zero
// R19 - Reserve control write-only, locked writes error/ignored
// R20 - Clear pipe command clears pipeline advance
// R21 - Clear sticky command clears error flags
// R22 - Debugger reads 64-bit registers as halves
module ext_debug_regs (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic        req_mmap_in,
  input  wire logic [11:0] req_addr_in,
  input  wire logic [31:0] req_wdata_in,
  output logic             rsp_valid_out,
  output logic      [31:0] rsp_rdata_out,
  output logic             rsp_error_out,
  input  wire logic        core_powered_in,
  input  wire logic        double_lock_in,
  input  wire logic        os_lock_in,
  input  wire logic        software_lock_in,
  input  wire logic        halted_in,
  input  wire logic        profiling_prohibited_in,
  input  wire logic        core_in_reset_in,
  input  wire logic        retire_in,
  input  wire logic [31:0] retire_pc_in,
  input  wire logic [31:0] retire_ctx_in,
  input  wire logic [7:0]  retire_vmid_in,
  input  wire logic        retire_regime_in,
  input  wire logic        transmit_underrun_event_in,
  input  wire logic        receive_overrun_event_in,
  input  wire logic        err_event_in,
  input  wire logic        instr_transfer_overrun_event_in,
  output logic             pipeline_advance_out,
  output logic             transmit_underrun_out,
  output logic             receive_overrun_out,
  output logic             cumulative_error_out,
  output logic             instr_transfer_overrun_out,
  output logic      [31:0] ctx_sample_out,
  output logic      [31:0] vm_sample_out
);
  import dbg_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
    addr_hit = (addr[11:2] == offset[11:2]);
  endfunction

  function automatic logic [31:0] put_field(input logic [3:0] value, input int lsb);
    put_field = 32'(value) << lsb;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_rc_w;
  logic hit_pc_w;
  logic hit_pfr_low_w;
  logic hit_pfr_high_w;
  logic hit_dfr_low_w;
  logic hit_dfr_high_w;

  assign hit_rc_w       = addr_hit(req_addr_in, OFF_RESERVE_CONTROL);
  assign hit_pc_w       = addr_hit(req_addr_in, OFF_PC_SAMPLE) & CFG_PC_SAMPLE_ON;  // [R11]
  assign hit_pfr_low_w  = addr_hit(req_addr_in, OFF_PFR_LOW);  // [R22]
  assign hit_pfr_high_w = addr_hit(req_addr_in, OFF_PFR_HIGH);  // [R22]
  assign hit_dfr_low_w  = addr_hit(req_addr_in, OFF_DFR_LOW);  // [R22]
  assign hit_dfr_high_w = addr_hit(req_addr_in, OFF_DFR_HIGH);  // [R22]

  // ----------------------------------------------------------------
  // Lock gating
  // ----------------------------------------------------------------
  logic    locked_err_w;
  logic    needs_lock_w;
  logic    swlock_w;
  access_t access_w;

  // Power off, double lock and OS lock refuse core-domain registers
  assign locked_err_w = ~core_powered_in | double_lock_in | os_lock_in;
  assign needs_lock_w = hit_pc_w | hit_rc_w;
  // Software lock only applies to accesses from the memory-mapped side
  assign swlock_w     = req_mmap_in & software_lock_in;
  assign access_w     = (needs_lock_w && locked_err_w) ? ACC_ERROR
                      : (hit_rc_w && req_write_in && swlock_w) ? ACC_IGNORE
                      : ACC_OK;  // [R19]

  // ----------------------------------------------------------------
  // Feature registers
  // ----------------------------------------------------------------
  logic [31:0] pfr_low_w;
  logic [31:0] dfr_low_w;

  assign pfr_low_w = put_field(CFG_IRQ_CTRL_IF, IRQ_CTRL_IF_LSB)  // [R12]
                   | put_field(CFG_VECTOR, VECTOR_LSB)  // [R13]
                   | put_field(CFG_FLOAT, FLOAT_LSB)  // [R14]
                   | put_field(STATE_NARROW_ONLY, TOP_LEVEL_LSB)  // [R15]
                   | put_field(STATE_NARROW_ONLY, HYP_LEVEL_LSB)  // [R16]
                   | put_field(STATE_NARROW_ONLY, KERNEL_LSB)  // [R17]
                   | put_field(STATE_NARROW_ONLY, USER_LSB);  // [R18]

  assign dfr_low_w = put_field(CFG_PERF_MON, PERF_MON_LSB)  // [R1]
                   | put_field(CFG_TRACE_IF, TRACE_IF_LSB);  // [R2]

  // ----------------------------------------------------------------
  // Program counter sample
  // ----------------------------------------------------------------
  logic        sample_read_w;
  logic [31:0] sample_value_w;

  assign sample_read_w = req_valid_in & ~req_write_in & hit_pc_w & (access_w == ACC_OK);

  pc_sampler sampler_u (
    .clock_in          (clock_in),
    .rstn_in           (rstn_in),
    .retire_in         (retire_in),
    .retire_pc_in      (retire_pc_in),
    .retire_ctx_in     (retire_ctx_in),
    .retire_vmid_in    (retire_vmid_in),
    .retire_regime_in  (retire_regime_in),
    .halted_in         (halted_in),
    .prohibited_in     (profiling_prohibited_in),
    .core_in_reset_in  (core_in_reset_in),
    .sample_read_in    (sample_read_w),
    .side_effect_en_in (~swlock_w),  // [R9]
    .sample_value_out  (sample_value_w),
    .ctx_sample_out    (ctx_sample_out),
    .vm_sample_out     (vm_sample_out)
  );

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  logic [31:0] rdata_w;

  // Reserve control is write-only and reads as zero, as do high halves
  assign rdata_w = (req_write_in || access_w != ACC_OK) ? READ_ZERO
                 : hit_pc_w      ? sample_value_w  // [R3] [R7]
                 : hit_pfr_low_w ? pfr_low_w
                 : hit_dfr_low_w ? dfr_low_w
                 : READ_ZERO;

  // ----------------------------------------------------------------
  // Reserve control commands
  // ----------------------------------------------------------------
  logic cmd_fire_w;
  logic clr_pipe_w;
  logic clr_sticky_w;

  assign cmd_fire_w   = req_valid_in & req_write_in & hit_rc_w & (access_w == ACC_OK);  // [R19]
  assign clr_pipe_w   = cmd_fire_w & req_wdata_in[CMD_CLEAR_PIPE_BIT];  // [R20]
  assign clr_sticky_w = cmd_fire_w & req_wdata_in[CMD_CLEAR_STICKY_BIT];  // [R21]

  // ----------------------------------------------------------------
  // Status flags, set wins over clear
  // ----------------------------------------------------------------
  logic       pipe_moved_r;
  logic       pipe_moved_nxt;
  logic       xfer_ovr_r;
  logic       xfer_ovr_nxt;
  logic [2:0] sticky_r;
  logic [2:0] sticky_set_w;
  logic [2:0] sticky_nxt;

  assign pipe_moved_nxt = retire_in | (pipe_moved_r & ~clr_pipe_w);  // [R20]
  assign xfer_ovr_nxt   = instr_transfer_overrun_event_in | (xfer_ovr_r & ~(clr_sticky_w & halted_in));  // [R21]
  assign sticky_set_w   = {err_event_in, receive_overrun_event_in, transmit_underrun_event_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sticky
      assign sticky_nxt[gi] = sticky_set_w[gi] | (sticky_r[gi] & ~clr_sticky_w);  // [R21]
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pipe_moved_r <= 1'b0;
      xfer_ovr_r   <= 1'b0;
      sticky_r     <= 3'h0;
    end else begin
      pipe_moved_r <= pipe_moved_nxt;
      xfer_ovr_r   <= xfer_ovr_nxt;
      sticky_r     <= sticky_nxt;
    end
  end

  assign pipeline_advance_out       = pipe_moved_r;
  assign transmit_underrun_out      = sticky_r[0];
  assign receive_overrun_out        = sticky_r[1];
  assign cumulative_error_out       = sticky_r[2];
  assign instr_transfer_overrun_out = xfer_ovr_r;

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= READ_ZERO;
      rsp_error_out <= 1'b0;
    end else begin
      rsp_valid_out <= req_valid_in;
      rsp_rdata_out <= req_valid_in ? rdata_w : READ_ZERO;
      rsp_error_out <= req_valid_in & (access_w == ACC_ERROR);  // [R19]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_locked_error: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R19]
    (req_valid_in && hit_rc_w && locked_err_w) |=> rsp_valid_out && rsp_error_out)
    else $error("locked reserve control access gave no error");
  a_swlock_write_ignored: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R19]
    (req_valid_in && req_write_in && hit_rc_w && swlock_w && !locked_err_w && pipe_moved_r)
      |=> pipe_moved_r && !rsp_error_out)
    else $error("software locked write was not ignored");
  a_pipe_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R20]
    (clr_pipe_w && !retire_in) ##1 !retire_in |=> !pipe_moved_r)
    else $error("pipeline advance not cleared");
  a_pipe_set_wins: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R20]
    (clr_pipe_w && retire_in) |=> pipe_moved_r)
    else $error("retirement lost against clear");
  a_sticky_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R21]
    (clr_sticky_w && !transmit_underrun_event_in && !receive_overrun_event_in && !err_event_in)
      |=> sticky_r == 3'h0)
    else $error("sticky errors not cleared");
  a_xfer_ovr_kept: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R21]
    (clr_sticky_w && !halted_in && xfer_ovr_r) |=> xfer_ovr_r)
    else $error("transfer overrun cleared while running");
  a_pfr_fields: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R12]
    (req_valid_in && !req_write_in && hit_pfr_low_w) |=>
      rsp_rdata_out[27:24] == CFG_IRQ_CTRL_IF && rsp_rdata_out[23:20] == CFG_VECTOR
      && rsp_rdata_out[19:16] == CFG_FLOAT && rsp_rdata_out[15:0] == 16'h0000)
    else $error("processor feature fields wrong");
  a_dfr_fields: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R1]
    (req_valid_in && !req_write_in && hit_dfr_low_w) |=>
      rsp_rdata_out[11:8] == CFG_PERF_MON && rsp_rdata_out[7:4] == CFG_TRACE_IF)
    else $error("debug feature fields wrong");
  a_pc_halt_ones: assert property (@(posedge clock_in) disable iff (!rstn_in)  // [R3]
    (sample_read_w && halted_in) |=> rsp_rdata_out == SAMPLE_ALL_ONES)
    else $error("halted sample read not all ones");
  a_rsp_follows: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_valid_in |=> rsp_valid_out ##1 (rsp_valid_out == $past(req_valid_in)))
    else $error("response not one cycle after request");

endmodule

// ### dbg_host_model.sv
// Debugger model: issues single register accesses on the debug port.
// Assumes a request is taken on a rising edge and answered on the next cycle.
`timescale 1ns/1ps
module dbg_host_model (
  input  wire logic        clock_in,
  input  wire logic        rsp_valid_in,
  input  wire logic [31:0] rsp_rdata_in,
  input  wire logic        rsp_error_in,
  output logic             req_valid_out,
  output logic             req_write_out,
  output logic             req_mmap_out,
  output logic      [11:0] req_addr_out,
  output logic      [31:0] req_wdata_out
);
  initial begin
    {req_valid_out, req_write_out, req_mmap_out} = 3'h0;
    req_addr_out = 12'h0;
    req_wdata_out = 32'h0;
  end

  // One access; released lines show the inverse so stale values never match
  task automatic access(input logic wr, input logic mm, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clock_in);
    {req_valid_out, req_write_out, req_mmap_out, req_addr_out, req_wdata_out} <= {1'b1, wr, mm, a, wd};
    @(posedge clock_in);
    {req_valid_out, req_addr_out, req_wdata_out} <= {1'b0, ~a, ~wd};
    do begin
      @(posedge clock_in);
      n++;
    end while (rsp_valid_in !== 1'b1 && n < 4);
    // A missing answer yields unknowns so that every later compare of rd or er fails
    rd = (rsp_valid_in === 1'b1) ? rsp_rdata_in : 32'hx;
    er = (rsp_valid_in === 1'b1) ? rsp_error_in : 1'bx;
  endtask

  // Wide register as two word reads, low half first
  task automatic read64(input logic [11:0] a, output logic [63:0] v);
    logic er;
    access(1'b0, 1'b0, a, 32'h0, v[31:0], er);
    access(1'b0, 1'b0, a + 12'h4, 32'h0, v[63:32], er);
  endtask
endmodule

// ### ext_debug_feature_and_pc_sample_tb.sv
// Self-checking bench for the debug feature, sample and reserve control registers.
// Assumes dbg_pkg, ext_debug_regs and dbg_host_model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ext_debug_feature_and_pc_sample_tb;
  import dbg_pkg::*;
  logic        clock_in, rstn_in, powered, dlock, olock, slock, halted, prohib, in_reset, retire, regime, er;
  logic [31:0] pc, ctx, rd, seed;
  logic [7:0]  vmid;
  logic [3:0]  ev;
  logic [63:0] v64;
  wire  logic        rq_v, rq_w, rq_m, rs_v, rs_e, pipe_f, tx_under_f, rx_over_f, err_f, xfer_ovr_f;
  wire  logic [11:0] rq_a;
  wire  logic [31:0] rq_d, rs_d, ctx_s, vm_s;
  int          err_count, cmp_count, cycles;

  ext_debug_regs i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .req_valid_in(rq_v), .req_write_in(rq_w),
    .req_mmap_in(rq_m), .req_addr_in(rq_a), .req_wdata_in(rq_d), .rsp_valid_out(rs_v), .rsp_rdata_out(rs_d),
    .rsp_error_out(rs_e), .core_powered_in(powered), .double_lock_in(dlock), .os_lock_in(olock),
    .software_lock_in(slock), .halted_in(halted), .profiling_prohibited_in(prohib),
    .core_in_reset_in(in_reset), .retire_in(retire), .retire_pc_in(pc), .retire_ctx_in(ctx),
    .retire_vmid_in(vmid), .retire_regime_in(regime), .transmit_underrun_event_in(ev[3]),
    .receive_overrun_event_in(ev[2]), .err_event_in(ev[1]), .instr_transfer_overrun_event_in(ev[0]),
    .pipeline_advance_out(pipe_f), .transmit_underrun_out(tx_under_f), .receive_overrun_out(rx_over_f),
    .cumulative_error_out(err_f), .instr_transfer_overrun_out(xfer_ovr_f),
    .ctx_sample_out(ctx_s), .vm_sample_out(vm_s));

  dbg_host_model i_host (.clock_in(clock_in), .rsp_valid_in(rs_v), .rsp_rdata_in(rs_d), .rsp_error_in(rs_e),
    .req_valid_out(rq_v), .req_write_out(rq_w), .req_mmap_out(rq_m), .req_addr_out(rq_a), .req_wdata_out(rq_d));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [31:0] vm_exp(input logic [31:0] p);
    return {p[3], 23'h0, p[15:8]};
  endfunction

  task automatic step(input logic [31:0] p);
    @(posedge clock_in);
    {retire, pc, ctx, vmid, regime} <= {1'b1, p, ~p, p[15:8], p[3]};
    @(posedge clock_in);
    retire <= 1'b0;
  endtask

  task automatic pulse_ev(input logic [3:0] e);
    @(posedge clock_in);
    ev <= e;
    @(posedge clock_in);
    ev <= 4'h0;
  endtask

  task automatic sample(input logic mm, input logic [31:0] exp_pc, input logic [31:0] exp_ctx);
    i_host.access(1'b0, mm, OFF_PC_SAMPLE, 32'h0, rd, er);
    `CHK(rd, exp_pc)
    `CHK(ctx_s, exp_ctx)
  endtask

  task automatic rc_write(input logic mm, input logic [31:0] d, input logic exp_er, input logic [4:0] exp_f);
    i_host.access(1'b1, mm, OFF_RESERVE_CONTROL, d, rd, er);
    `CHK(er, exp_er)
    `CHK({pipe_f, tx_under_f, rx_over_f, err_f, xfer_ovr_f}, exp_f)
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {rstn_in, dlock, olock, slock, halted, prohib, in_reset, retire, regime, powered} = 10'h1;
    {pc, ctx, vmid, ev, err_count, cmp_count, cycles} = '0;
    seed = 32'h5be8;
    repeat (10) @(posedge clock_in);
    rstn_in <= 1'b1;
    `CHK(ctx_s, SAMPLE_RESET)
    sample(1'b0, SAMPLE_ALL_ONES, SAMPLE_ALL_ONES);
    i_host.access(1'b1, 1'b0, OFF_PFR_LOW, 32'hffffffff, rd, er);
    i_host.read64(OFF_PFR_LOW, v64);
    `CHK(v64, {36'h0, CFG_IRQ_CTRL_IF, CFG_VECTOR, CFG_FLOAT, 16'h0})
    i_host.read64(OFF_DFR_LOW, v64);
    `CHK(v64, {48'h0, CFG_PERF_MON, CFG_TRACE_IF, 4'h0})
    i_host.access(1'b0, 1'b0, 12'h100, 32'h0, rd, er);
    `CHK({er, rd}, 33'h0)
    for (int i = 0; i < 6; i++) begin
      seed = nxt(seed);
      step(seed);
      sample(1'b0, seed, ~seed);
      `CHK(vm_s, vm_exp(seed))
      sample(1'b0, SAMPLE_ALL_ONES, SAMPLE_ALL_ONES);
    end
    for (int k = 0; k < 3; k++) begin
      {halted, prohib, in_reset} <= 3'h4 >> k;
      step(32'h1000 + k);
      sample(1'b0, SAMPLE_ALL_ONES, SAMPLE_ALL_ONES);
    end
    {halted, prohib, in_reset} <= 3'h0;
    step(32'h2468ace0);
    slock <= 1'b1;
    sample(1'b1, 32'h2468ace0, SAMPLE_ALL_ONES);
    pulse_ev(4'hf);
    step(32'h55aa);
    for (int j = 0; j < 3; j++) begin
      {powered, dlock, olock} <= {j != 0, j == 1, j == 2};
      rc_write(1'b0, 32'hc, 1'b1, 5'h1f);
      i_host.access(1'b0, 1'b0, OFF_PC_SAMPLE, 32'h0, rd, er);
      `CHK(er, 1'b1)
    end
    {powered, dlock, olock} <= 3'h4;
    rc_write(1'b1, 32'hc, 1'b0, 5'h1f);
    rc_write(1'b0, 32'h0, 1'b0, 5'h1f);
    rc_write(1'b0, 32'h8, 1'b0, 5'h0f);
    rc_write(1'b0, 32'h4, 1'b0, 5'h01);
    halted <= 1'b1;
    rc_write(1'b0, 32'h4, 1'b0, 5'h00);
    i_host.access(1'b0, 1'b0, OFF_RESERVE_CONTROL, 32'h0, rd, er);
    `CHK({er, rd}, 33'h0)
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    `CHK(ctx_s, SAMPLE_RESET)
    final_report();
  end
endmodule
